// *** rtl/hmsl_unit.sv ***
// halfword, multiple-word and string load execution unit
`timescale 1ns/1ns
`include "hmsl_regs.svh"
module hmsl_unit (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        nrst,
   // instruction issue
   input  wire logic        issue_valid,
   output logic             issue_ready,
   input  wire logic [31:0] instr,
   input  wire logic        restart,
   // register file read ports
   output logic [4:0]       rd_a_addr,
   output logic [4:0]       rd_b_addr,
   input  wire logic [31:0] rd_a_data,
   input  wire logic [31:0] rd_b_data,
   // register file write port
   output logic             gpr_we,
   output logic [4:0]       gpr_waddr,
   output logic [31:0]      gpr_wdata,
   // storage read
   output logic             mem_req,
   output logic [31:0]      mem_addr,
   output logic [1:0]       mem_size,
   input  wire logic        mem_ack,
   input  wire logic [31:0] mem_rdata,
   // status
   output logic             busy,
   output logic             invalid_form,
   output logic             cr0_undefined
);
   import hmsl_pkg::*;

   // ==========================================================
   // decode
   hmsl_state_s_t s_q, s_d;
   logic [5:0]  opc;
   logic [9:0]  xo;
   logic [4:0]  f_rt, f_ra, f_rb;
   logic        is_x, dec_ok, rsv_bad;
   hmsl_op_t    dec_op;
   logic        dec_upd, dec_idx, dec_str;
   logic [31:0] base_v, ea_v;
   logic [5:0]  cnt_v;

   assign opc  = instr[31:`HMSL_OPC_POS];
   assign f_rt = instr[25:`HMSL_RT_POS];
   assign f_ra = instr[20:`HMSL_RA_POS];
   assign f_rb = instr[15:`HMSL_RB_POS];
   assign xo   = instr[10:`HMSL_XO_POS];
   assign is_x = (opc == `HMSL_OPC_X);
   assign rd_a_addr = f_ra;
   assign rd_b_addr = f_rb;

   always_comb
   begin
      dec_ok  = 1'b1;
      dec_op  = HMSL_OP_HALF_S;
      dec_upd = 1'b0;
      dec_idx = is_x;
      dec_str = 1'b0;
      if (is_x)
      begin
         unique case (xo)
            `HMSL_XO_LOAD_HALF_SIGNED_INDEXED:  dec_op = HMSL_OP_HALF_S;
            `HMSL_XO_LOAD_HALF_SIGNED_UPDATE_INDEXED:
            begin
               dec_op  = HMSL_OP_HALF_S;
               dec_upd = 1'b1;
            end
            `HMSL_XO_LOAD_HALF_REVERSED_INDEXED: dec_op = HMSL_OP_HALF_R;
            `HMSL_XO_LOAD_HALF_ZERO_INDEXED:  dec_op = HMSL_OP_HALF_Z;
            `HMSL_XO_LOAD_HALF_ZERO_UPDATE_INDEXED:
            begin
               dec_op  = HMSL_OP_HALF_Z;
               dec_upd = 1'b1;
            end
            `HMSL_XO_LSWI:
            begin
               dec_op  = HMSL_OP_STRING;
               dec_str = 1'b1;
               dec_idx = 1'b0;
            end
            default: dec_ok = 1'b0;
         endcase
      end
      else
      begin
         unique case (opc)
            `HMSL_OPC_LHZ:  dec_op = HMSL_OP_HALF_Z;
            `HMSL_OPC_LHZU:
            begin
               dec_op  = HMSL_OP_HALF_Z;
               dec_upd = 1'b1;
            end
            `HMSL_OPC_LHA:  dec_op = HMSL_OP_HALF_S;
            `HMSL_OPC_LHAU:
            begin
               dec_op  = HMSL_OP_HALF_S;
               dec_upd = 1'b1;
            end
            `HMSL_OPC_LMW:  dec_op = HMSL_OP_MULTI;
            default: dec_ok = 1'b0;
         endcase
      end
   end

   // reserved field (bit 0 of X forms is record bit, not reserved)
   assign rsv_bad = 1'b0;

   // ==========================================================
   // address generation
   always_comb
   begin
      base_v = (f_ra == 5'h00) ? 32'h0000_0000 : rd_a_data;
      if (dec_str)
         ea_v = base_v;
      else if (dec_idx)
         ea_v = base_v + rd_b_data;
      else
         ea_v = base_v + {{16{instr[15]}}, instr[15:0]};
      cnt_v = (f_rb == 5'h00) ? `HMSL_CNT_ZERO : {1'b0, f_rb};
   end

   // ==========================================================
   // sequencer
   always_comb
   begin
      s_d = s_q;
      s_d.gpr_we = 1'b0;
      unique case (s_q.st)
         HMSL_IDLE:
         begin
            if (issue_valid && dec_ok)
            begin
               s_d.st     = HMSL_RDRQ;
               s_d.op     = dec_op;
               s_d.ea     = ea_v;
               s_d.reg_n  = f_rt;
               s_d.base_n = f_ra;
               s_d.upd    = dec_upd;
               s_d.left   = cnt_v;
               s_d.acc    = 32'h0000_0000;
               s_d.bpos   = 2'h0;
               s_d.busy   = 1'b1;
               s_d.inv    = rsv_bad | (dec_upd &&
                            (f_ra == 5'h00 || f_ra == f_rt));
            end
            else if (issue_valid)
               s_d.inv = 1'b1;
         end
         HMSL_RDRQ:
         begin
            if (restart)
            begin
               s_d.st   = HMSL_IDLE;
               s_d.busy = 1'b0;
            end
            else if (mem_ack)
               s_d.st = HMSL_WAIT;
         end
         HMSL_WAIT:
         begin
            s_d.st = HMSL_RDRQ;
            unique case (s_q.op)
               HMSL_OP_HALF_S, HMSL_OP_HALF_Z, HMSL_OP_HALF_R:
               begin
                  if (s_q.upd)
                  begin
                     s_d.gpr_we = 1'b1;
                     s_d.gpr_wa = s_q.base_n;
                     s_d.gpr_wd = s_q.ea;
                     s_d.upd    = 1'b0;
                     s_d.st     = HMSL_WAIT;
                  end
                  else
                  begin
                     s_d.st   = HMSL_IDLE;
                     s_d.busy = 1'b0;
                  end
               end
               HMSL_OP_MULTI:
               begin
                  s_d.ea    = s_q.ea + 32'h0000_0004;
                  s_d.reg_n = s_q.reg_n + 5'h01;
                  if (s_q.reg_n == `HMSL_LAST_REG)
                  begin
                     s_d.st   = HMSL_IDLE;
                     s_d.busy = 1'b0;
                  end
               end
               default:
               begin
                  s_d.ea = s_q.ea + 32'h0000_0001;
                  s_d.bpos = s_q.bpos + 2'h1;
                  s_d.left = s_q.left - 6'h01;
                  if (s_q.bpos == 2'h3)
                  begin
                     s_d.acc   = 32'h0000_0000;
                     s_d.reg_n = s_q.reg_n + 5'h01;
                  end
                  if (s_q.left == 6'h01)
                  begin
                     s_d.st   = HMSL_IDLE;
                     s_d.busy = 1'b0;
                  end
               end
            endcase
         end
         default: s_d.st = HMSL_IDLE;
      endcase
      // load result captured when storage answers
      if (s_q.st == HMSL_RDRQ && mem_ack && !restart)
      begin
         s_d.gpr_we = 1'b1;
         s_d.gpr_wa = s_q.reg_n;
         unique case (s_q.op)
            HMSL_OP_HALF_S:
               s_d.gpr_wd = {{16{mem_rdata[15]}}, mem_rdata[15:0]};
            HMSL_OP_HALF_Z:
               s_d.gpr_wd = {16'h0000, mem_rdata[15:0]};
            HMSL_OP_HALF_R:
               s_d.gpr_wd = {16'h0000, mem_rdata[7:0],
                             mem_rdata[15:8]};
            HMSL_OP_MULTI:
               s_d.gpr_wd = mem_rdata;
            default:
            begin
               // byte lands high-first, lower bits stay zero
               s_d.acc = s_q.acc | ({mem_rdata[7:0], 24'h000000}
                         >> {s_q.bpos, 3'h0});
               s_d.gpr_we = (s_q.bpos == 2'h3) || (s_q.left == 6'h01);
               s_d.gpr_wd = s_d.acc;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_q <= '{st: HMSL_IDLE, op: HMSL_OP_HALF_S, default: '0};
      end
      else
         s_q <= s_d;
   end

   // ==========================================================
   // outputs
   assign issue_ready   = (s_q.st == HMSL_IDLE);
   assign busy          = s_q.busy;
   assign gpr_we        = s_q.gpr_we;
   assign gpr_waddr     = s_q.gpr_wa;
   assign gpr_wdata     = s_q.gpr_wd;
   assign mem_req       = (s_q.st == HMSL_RDRQ);
   assign mem_addr      = s_q.ea;
   assign mem_size      = (s_q.op == HMSL_OP_STRING) ? 2'h0 :
                          (s_q.op == HMSL_OP_MULTI) ? 2'h2 : 2'h1;
   assign invalid_form  = s_q.inv;
   assign cr0_undefined = issue_valid && issue_ready && is_x &&
                          instr[0];

   // ==========================================================
   // assertions
   AST_HALF_SIGN: assert property (@(posedge mclk) disable iff (!nrst)
      (s_q.st == HMSL_RDRQ && mem_ack && !restart
       && s_q.op == HMSL_OP_HALF_S)
      |=> gpr_we && gpr_wdata[31:16] == {16{$past(mem_rdata[15])}})
      else $error("signed halfword not extended");
   AST_HALF_ZERO: assert property (@(posedge mclk) disable iff (!nrst)
      (s_q.st == HMSL_RDRQ && mem_ack && !restart
       && s_q.op == HMSL_OP_HALF_Z)
      |=> gpr_wdata == {16'h0000, $past(mem_rdata[15:0])})
      else $error("zero halfword wrong");
   AST_HALF_REV: assert property (@(posedge mclk) disable iff (!nrst)
      (s_q.st == HMSL_RDRQ && mem_ack && !restart
       && s_q.op == HMSL_OP_HALF_R)
      |=> gpr_wdata[15:8] == $past(mem_rdata[7:0])
          && gpr_wdata[7:0] == $past(mem_rdata[15:8])
          && gpr_wdata[31:16] == 16'h0000)
      else $error("reversed halfword wrong");
   AST_UPD_BASE: assert property (@(posedge mclk) disable iff (!nrst)
      (s_q.st == HMSL_WAIT && s_q.upd && s_q.op != HMSL_OP_MULTI
       && s_q.op != HMSL_OP_STRING)
      |=> gpr_we && gpr_waddr == $past(s_q.base_n)
          && gpr_wdata == $past(s_q.ea))
      else $error("base not updated");
   AST_STR_ADDR: assert property (@(posedge mclk) disable iff (!nrst)
      (issue_ready && issue_valid && is_x && xo == `HMSL_XO_LSWI
       && f_ra == 5'h00) |=> mem_addr == 32'h0000_0000)
      else $error("string base not zero");
   AST_STR_CNT: assert property (@(posedge mclk) disable iff (!nrst)
      (issue_ready && issue_valid && is_x && xo == `HMSL_XO_LSWI
       && f_rb == 5'h00) |=> s_q.left == 6'h20)
      else $error("zero count not 32");
   AST_DISP_EA: assert property (@(posedge mclk) disable iff (!nrst)
      (issue_ready && issue_valid && !is_x && dec_ok && f_ra == 5'h00)
      |=> mem_addr == {{16{$past(instr[15])}}, $past(instr[15:0])})
      else $error("displacement address wrong");
   AST_MULTI_END: assert property (@(posedge mclk) disable iff (!nrst)
      (s_q.st == HMSL_WAIT && s_q.op == HMSL_OP_MULTI
       && s_q.reg_n == 5'h1f) |=> !busy)
      else $error("multiple load overran");
   AST_RESTART: assert property (@(posedge mclk) disable iff (!nrst)
      (s_q.st == HMSL_RDRQ && restart) |=> issue_ready && !gpr_we && !busy)
      else $error("restart not honoured");
   COV_STRING: cover property (@(posedge mclk) disable iff (!nrst)
      s_q.op == HMSL_OP_STRING && s_q.st == HMSL_WAIT && s_q.left == 6'h01);
   COV_MULTI: cover property (@(posedge mclk) disable iff (!nrst)
      s_q.op == HMSL_OP_MULTI && s_q.reg_n == 5'h1f);
   COV_UPD: cover property (@(posedge mclk) disable iff (!nrst)
      s_q.st == HMSL_WAIT && s_q.upd);
endmodule

// *** common/hmsl_regs.svh ***
// constants for the halfword, multiple and string load unit
`ifndef HMSL_REGS_SVH
`define HMSL_REGS_SVH
`define HMSL_OPC_POS     26
`define HMSL_RT_POS      21
`define HMSL_RA_POS      16
`define HMSL_RB_POS      11
`define HMSL_XO_POS      1
`define HMSL_OPC_X       6'h1f
`define HMSL_XO_LSWI     10'h255
`define HMSL_XO_LOAD_HALF_SIGNED_INDEXED     10'h157
`define HMSL_XO_LOAD_HALF_SIGNED_UPDATE_INDEXED    10'h177
`define HMSL_XO_LOAD_HALF_REVERSED_INDEXED    10'h316
`define HMSL_XO_LOAD_HALF_ZERO_INDEXED     10'h117
`define HMSL_XO_LOAD_HALF_ZERO_UPDATE_INDEXED    10'h137
`define HMSL_OPC_LHZ     6'h28
`define HMSL_OPC_LHZU    6'h29
`define HMSL_OPC_LHA     6'h2a
`define HMSL_OPC_LHAU    6'h2b
`define HMSL_OPC_LMW     6'h2e
`define HMSL_CNT_ZERO    6'h20
`define HMSL_LAST_REG    5'h1f
`endif

// *** common/hmsl_pkg.sv ***
// types for the halfword, multiple and string load unit
package hmsl_pkg;
   typedef enum logic [1:0] {
      HMSL_IDLE = 2'h0,
      HMSL_RDRQ = 2'h1,
      HMSL_WAIT = 2'h3
   } hmsl_state_t;

   typedef enum logic [2:0] {
      HMSL_OP_HALF_S  = 3'h0,
      HMSL_OP_HALF_Z  = 3'h1,
      HMSL_OP_HALF_R  = 3'h2,
      HMSL_OP_MULTI   = 3'h3,
      HMSL_OP_STRING  = 3'h4
   } hmsl_op_t;

   typedef struct packed {
      hmsl_state_t st;
      hmsl_op_t    op;
      logic [31:0] ea;
      logic [4:0]  reg_n;
      logic [4:0]  base_n;
      logic        upd;
      logic [5:0]  left;
      logic [31:0] acc;
      logic [1:0]  bpos;
      logic        busy;
      logic        gpr_we;
      logic [4:0]  gpr_wa;
      logic [31:0] gpr_wd;
      logic        inv;
   } hmsl_state_s_t;
endpackage

// *** verif/hmsl_mem_model.sv ***
// storage model answering byte, halfword and word reads
`timescale 1ns/1ns
module hmsl_mem_model (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        nrst,
   // request
   input  wire logic        mem_req,
   input  wire logic [31:0] mem_addr,
   input  wire logic [1:0]  mem_size,
   input  wire logic [4:0]  lat,
   // answer
   output logic             mem_ack,
   output logic [31:0]      mem_rdata
);
   logic [4:0]  cnt_q;
   logic [31:0] word;

   function automatic logic [7:0] mb(input logic [31:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h9c;
   endfunction

   // big-endian word at the address; unused upper bits carry noise
   assign word = {mb(mem_addr), mb(mem_addr + 32'h1),
                  mb(mem_addr + 32'h2), mb(mem_addr + 32'h3)};

   // ===========================================================
   // answer after lat cycles; outside answers the data toggles
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt_q     <= 5'h0;
         mem_ack   <= 1'b0;
         mem_rdata <= 32'h0;
      end
      else if (mem_req && !mem_ack && cnt_q >= lat)
      begin
         cnt_q     <= 5'h0;
         mem_ack   <= 1'b1;
         mem_rdata <= (mem_size == 2'h2) ? word :
                      (mem_size == 2'h1) ? {~word[15:0], word[31:16]} :
                                           {~word[31:8], word[31:24]};
      end
      else
      begin
         mem_ack   <= 1'b0;
         cnt_q     <= mem_req ? cnt_q + 5'h1 : 5'h0;
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule

// *** verif/hmsl_unit_test.sv ***
// self-checking bench for the load unit
`timescale 1ns/1ns
`include "hmsl_regs.svh"
module hmsl_unit_test;
   import hmsl_pkg::*;
   logic        mclk = 0;
   logic        nrst = 0;
   logic        issue_valid = 0;
   logic [31:0] instr = 0;
   logic        restart = 0;
   logic [4:0]  lat = 0;
   logic [4:0]  rd_a_addr, rd_b_addr, gpr_waddr;
   logic [31:0] rd_a_data, rd_b_data, gpr_wdata, mem_addr, mem_rdata;
   logic        issue_ready, gpr_we, mem_req, mem_ack, busy;
   logic        invalid_form, cr0_undefined;
   logic [1:0]  mem_size;
   logic [31:0] general_purpose_reg [32];
   logic [36:0] exp_q [$];
   logic [31:0] seed = 35;
   int          fail_count = 0;
   int          checks_done = 0;
   int          cyc = 0;
   // halfword forms, record bit set on some indexed ones
   localparam logic [31:0] HW [10] = '{
      {`HMSL_OPC_X, 5'd3, 5'd0, 5'd5, `HMSL_XO_LOAD_HALF_SIGNED_INDEXED, 1'b1},
      {`HMSL_OPC_X, 5'd3, 5'd4, 5'd5, `HMSL_XO_LOAD_HALF_SIGNED_INDEXED, 1'b0},
      {`HMSL_OPC_X, 5'd6, 5'd4, 5'd5, `HMSL_XO_LOAD_HALF_SIGNED_UPDATE_INDEXED, 1'b1},
      {`HMSL_OPC_X, 5'd7, 5'd4, 5'd5, `HMSL_XO_LOAD_HALF_ZERO_INDEXED, 1'b0},
      {`HMSL_OPC_X, 5'd8, 5'd9, 5'd5, `HMSL_XO_LOAD_HALF_ZERO_UPDATE_INDEXED, 1'b0},
      {`HMSL_OPC_X, 5'd10, 5'd4, 5'd5, `HMSL_XO_LOAD_HALF_REVERSED_INDEXED, 1'b1},
      {`HMSL_OPC_LHZ, 5'd11, 5'd4, 16'h0},
      {`HMSL_OPC_LHZU, 5'd12, 5'd13, 16'h0},
      {`HMSL_OPC_LHA, 5'd14, 5'd0, 16'h0},
      {`HMSL_OPC_LHAU, 5'd15, 5'd16, 16'h0}};
   localparam int HK [10] = '{0, 0, 0, 1, 1, 2, 1, 1, 0, 0};
   localparam int HU [10] = '{0, 0, 1, 0, 1, 0, 0, 1, 0, 1};

   always #5 mclk = ~mclk;
   assign rd_a_data = general_purpose_reg[rd_a_addr];
   assign rd_b_data = general_purpose_reg[rd_b_addr];

   hmsl_unit hmsl_unit_i (.mclk, .nrst, .issue_valid, .issue_ready, .instr,
      .restart, .rd_a_addr, .rd_b_addr, .rd_a_data, .rd_b_data, .gpr_we,
      .gpr_waddr, .gpr_wdata, .mem_req, .mem_addr, .mem_size, .mem_ack,
      .mem_rdata, .busy, .invalid_form, .cr0_undefined);
   hmsl_mem_model hmsl_mem_model_i (.mclk, .nrst, .mem_req, .mem_addr,
      .mem_size, .lat, .mem_ack, .mem_rdata);

   // ===========================================================
   // helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] mb(input logic [31:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h9c;
   endfunction
   function automatic logic [31:0] mw(input logic [31:0] a);
      return {mb(a), mb(a + 32'h1), mb(a + 32'h2), mb(a + 32'h3)};
   endfunction
   task automatic check(input string nm, input logic [36:0] e,
                        input logic [36:0] s);
      checks_done++;
      if (s !== e)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic issue(input logic [31:0] w, input logic [4:0] l);
      logic rc;
      rc = (w[31:26] == `HMSL_OPC_X) && w[0];
      while (issue_ready !== 1'b1)
         @(negedge mclk);
      @(posedge mclk);
      issue_valid <= 1'b1;
      instr       <= w;
      lat         <= l;
      @(negedge mclk);
      check("cr0", {36'h0, rc}, {36'h0, cr0_undefined});
      @(posedge mclk);
      issue_valid <= 1'b0;
   endtask
   task automatic done(input string nm);
      int k;
      for (k = 0; k < 600; k++)
      begin
         @(negedge mclk);
         if (exp_q.size() == 0 && issue_ready === 1'b1 && busy === 1'b0)
            break;
      end
      check("idle", 37'h1, {36'h0, k < 600});
      $display("test %s done", nm);
   endtask
   task automatic run_half(input logic [31:0] w, input int k, input int u);
      logic [31:0] ea;
      logic [31:0] h;
      logic [15:0] d;
      d  = w[15:0];
      ea = (w[20:16] == 5'h0) ? 32'h0 : general_purpose_reg[w[20:16]];
      if (w[31:26] == `HMSL_OPC_X)
         ea = ea + general_purpose_reg[w[15:11]];
      else
         ea = ea + {{16{d[15]}}, d};
      h  = mw(ea);
      if (k == 0)
         exp_q.push_back({w[25:21], {16{h[31]}}, h[31:16]});
      else if (k == 1)
         exp_q.push_back({w[25:21], 16'h0, h[31:16]});
      else
         exp_q.push_back({w[25:21], 16'h0, h[23:16], h[31:24]});
      if (u != 0)
         exp_q.push_back({w[20:16], ea});
      issue(w, 5'(rnd() & 32'h3));
      done("halfword");
   endtask
   task automatic run_multi(input logic [4:0] rt, input logic [15:0] d,
                            input logic [4:0] l);
      logic [31:0] ea;
      ea = general_purpose_reg[4] + {{16{d[15]}}, d};
      for (int r = rt; r < 32; r++)
         exp_q.push_back({5'(r), mw(ea + 32'(4 * (r - rt)))});
      issue({`HMSL_OPC_LMW, rt, 5'd4, d}, l);
      done("multiple");
   endtask
   task automatic run_str(input logic [4:0] rt, input logic [4:0] ra,
                          input logic [4:0] nb);
      logic [31:0] ea;
      logic [31:0] acc;
      logic [31:0] w;
      int          cnt;
      ea  = (ra == 5'h0) ? 32'h0 : general_purpose_reg[ra];
      cnt = (nb == 5'h0) ? 32 : int'(nb);
      acc = 32'h0;
      for (int i = 0; i < cnt; i++)
      begin
         acc[31 - 8 * (i % 4) -: 8] = mb(ea + 32'(i));
         if (i % 4 == 3 || i == cnt - 1)
         begin
            exp_q.push_back({5'(rt + i / 4), acc});
            acc = 32'h0;
         end
      end
      w = {`HMSL_OPC_X, rt, ra, nb, `HMSL_XO_LSWI, 1'b1};
      issue(w, 5'(rnd() & 32'h3));
      done("string");
   endtask

   // ===========================================================
   // write monitor and hang guard
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fail_count++;
         wrap_up();
      end
      if (gpr_we === 1'b1)
      begin
         if (exp_q.size() == 0)
            check("spare write", 'x, {gpr_waddr, gpr_wdata});
         else
            check("write", exp_q.pop_front(), {gpr_waddr, gpr_wdata});
         general_purpose_reg[gpr_waddr] <= gpr_wdata;
      end
   end

   // ===========================================================
   // main sequence
   initial
   begin
      logic [31:0] r;
      logic [31:0] w;
      for (int i = 0; i < 32; i++)
         general_purpose_reg[i] = rnd();
      repeat (20) @(posedge mclk);
      nrst <= 1'b1;
      issue(32'h0, 5'h0);
      done("invalid");
      check("invalid", 37'h1, {36'h0, invalid_form});
      for (int i = 0; i < 10; i++)
      begin
         r = rnd();
         w = HW[i];
         if (w[31:26] != `HMSL_OPC_X)
            w[15:0] = r[15:0];
         run_half(w, HK[i], HU[i]);
      end
      check("invalid", 37'h0, {36'h0, invalid_form});
      // update form with a zero base still runs but is flagged
      run_half({`HMSL_OPC_LHZU, 5'd12, 5'd0, 16'h0010}, 1, 1);
      check("invalid", 37'h1, {36'h0, invalid_form});
      run_multi(5'd29, 16'hfff8, 5'd3);
      run_multi(5'd31, 16'h0024, 5'd0);
      issue({`HMSL_OPC_LMW, 5'd28, 5'd4, 16'h0010}, 5'd20);
      repeat (3) @(posedge mclk);
      restart <= 1'b1;
      @(posedge mclk);
      restart <= 1'b0;
      done("abort");
      run_multi(5'd28, 16'h0010, 5'd2);
      run_str(5'd20, 5'd4, 5'd0);
      run_str(5'd30, 5'd4, 5'd9);
      run_str(5'd10, 5'd0, 5'd6);
      wrap_up();
   end
endmodule
